// [core/pws_consts.svh]
`ifndef PWS_CONSTS_SVH
`define PWS_CONSTS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define PWS_OFS_STATUS 8'h00
`define PWS_OFS_IRQ_FLAG 8'h04
`define PWS_OFS_IRQ_MASK 8'h08
`define PWS_OFS_WD_CTRL 8'h0c
`define PWS_OFS_CONFIG 8'h10
`define PWS_OFS_IDENT 8'h14

// Status register fields.
`define PWS_ST_TEMP_LOW 0
`define PWS_ST_TEMP_HIGH 1
`define PWS_ST_OVERTEMP_LOCKOUT 2
`define PWS_ST_WD_EXP 3
`define PWS_ST_RAIL 4
`define PWS_ST_INQ_LSB 5

// Watchdog control fields.
`define PWS_WD_EN 0
`define PWS_WD_KICK 1
`define PWS_WD_PER_LSB 2
`define PWS_WD_LOCK 4

// Configuration fields.
`define PWS_CFG_USB_SUSP 0
`define PWS_CFG_PULLUP 1

// Reset values and codes.
`define PWS_MASK_RST 2'h3
`define PWS_PER_RST 2'h3
`define PWS_INQ_VALID 2'h3
`define PWS_CHIP_ID 4'ha
`define PWS_RESP_OKAY 2'h0
`define PWS_RESP_SLVERR 2'h2

// Timing.
`define PWS_CLK_HZ 20000000
`define PWS_TICK_US 62500
`define PWS_TICK_CYCLES (`PWS_TICK_US * (`PWS_CLK_HZ / 1000000))
`define PWS_WD_MIN_S 16
`define PWS_WD_MIN_TICKS (`PWS_WD_MIN_S * 1000000 / `PWS_TICK_US)

`endif

// [core/pws_pkg.sv]
`default_nettype none

package pws_pkg;

	// Inputs that arrive from analog comparators and straps.
	typedef struct packed {
		logic temp_low;
		logic temp_high;
		logic temp_over;
		logic temp_rel;
		logic sys_por;
		logic chg_por;
		logic chg_uvlo;
		logic [1:0] in_qual;
		logic strap_lock;
		logic strap_en;
	} pws_pins_t;

	typedef struct packed {
		pws_pins_t sync1;
		pws_pins_t sync2;
		logic [1:0] cap_cnt;
		logic lock;
		logic en_def;
		logic wd_en;
		logic [1:0] wd_per;
		logic [11:0] wd_cnt;
		logic [24:0] tick_cnt;
		logic wd_exp;
		logic [1:0] temp_stat;
		logic overtemp_lockout;
		logic [1:0] flags;
		logic [1:0] mask;
		logic usb_susp;
		logic pullup_sel;
		logic rail_reg;
		logic sys_por;
		logic sys_rst;
		logic chg_pg_rst;
		logic chg_por_rst;
		logic irq_oe;
		logic irq_o;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} pws_state_t;

endpackage

`default_nettype wire

// [core/pws_supervisor.sv]
`include "pws_consts.svh"
`default_nettype none

// Contract
// - Interrupt pin is open-drain, active low, released otherwise.
// - Pin low while any unmasked interrupt flag is set.
// - All masks reset to masked; masked flags never reach the pin.
// - Watchdog reaching its period unkicked raises the expiry flag.
// - Watchdog counts only while its enable bit is one.
// - Two-bit period picks 16 to 128 s, resets to 128 s.
// - Kick bit restarts the watchdog count from zero.
// - Lock bit is read-only and set by factory strap.
// - Unlocked: enable freely written; resets to factory default.
// - Locked: writing one enables, writing zero ignored.
// - Locked with default one: enable can never clear.
// - Two temperature alarm bits; any change sets own maskable flag.
// - Lockout above 165 C, released only about 15 C lower.
// - Each bit returns to default when its reset domain activates.
// - System power-on reset active while supply below about 1.9 V.
// - System reset is power-on reset or shutdown transitions 0A/0C.
// - Charger good reset: charger POR, USB suspend or undervoltage.
// - Charger power-on reset active while input below about 1.9 V.
// - Always-on rail from regulator if quality 0b11 and unsuspended.
// - Enable default and lock are taken from the factory straps.
// - Expiry flag clears during controller reset or off actions.
module pws_supervisor #(
	parameter int unsigned TICK_CYCLES = `PWS_TICK_CYCLES
) (
	input wire logic CLK_IN, // 20 MHz clock
	input wire logic RST_B_IN, // async reset, active low
	input wire logic CE_IN, // clock enable, freezes state when low
	input wire logic [7:0] AXI_AWADDR_IN, // write address
	input wire logic AXI_AWVALID_IN, // write address valid
	output logic AXI_AWREADY_OUT, // write address ready
	input wire logic [31:0] AXI_WDATA_IN, // write data
	input wire logic [3:0] AXI_WSTRB_IN, // write byte strobes
	input wire logic AXI_WVALID_IN, // write data valid
	output logic AXI_WREADY_OUT, // write data ready
	output logic [1:0] AXI_BRESP_OUT, // write response
	output logic AXI_BVALID_OUT, // write response valid
	input wire logic AXI_BREADY_IN, // write response ready
	input wire logic [7:0] AXI_ARADDR_IN, // read address
	input wire logic AXI_ARVALID_IN, // read address valid
	output logic AXI_ARREADY_OUT, // read address ready
	output logic [31:0] AXI_RDATA_OUT, // read data
	output logic [1:0] AXI_RRESP_OUT, // read response
	output logic AXI_RVALID_OUT, // read data valid
	input wire logic AXI_RREADY_IN, // read data ready
	input wire logic TEMP_ABOVE_80_IN, // junction above low alarm
	input wire logic TEMP_ABOVE_100_IN, // junction above high alarm
	input wire logic TEMP_ABOVE_165_IN, // junction above lockout
	input wire logic TEMP_BELOW_150_IN, // junction below lockout release
	input wire logic SYS_BELOW_POR_IN, // system supply below 1.9 V
	input wire logic CHG_BELOW_POR_IN, // charger input below 1.9 V
	input wire logic CHG_UVLO_IN, // charger input undervoltage
	input wire logic [1:0] INPUT_QUALITY_IN, // charger input quality
	input wire logic STRAP_LOCK_IN, // factory watchdog lock strap
	input wire logic STRAP_WD_EN_IN, // factory watchdog enable strap
	input wire logic SHUTDOWN_TRANS_IN, // controller takes 0A or 0C
	input wire logic RESET_ACTIONS_IN, // controller reset/off actions
	output logic IRQ_N_OUT, // interrupt pin output level
	output logic IRQ_N_OE_OUT, // interrupt pin pull-low enable
	output logic WD_EXPIRED_OUT, // watchdog expiry flag
	output logic OVERTEMP_LOCKOUT_OUT, // overtemperature lockout
	output logic RAIL_FROM_REG_OUT, // always-on rail from regulator
	output logic WEAK_PULLUP_OUT, // on-key weak pullup select
	output logic SYS_POR_OUT, // system power-on reset domain
	output logic SYS_RST_OUT, // system reset domain
	output logic CHG_PG_RST_OUT, // charger power-good reset domain
	output logic CHG_POR_OUT // charger power-on reset domain
);

	pws_pkg::pws_state_t st;
	pws_pkg::pws_state_t nx;
	pws_pkg::pws_pins_t pins;
	logic tick;
	logic wr_go;
	logic wr_lo;
	logic kick;
	logic exp_set;
	logic dom_sys_por;
	logic dom_sys;
	logic dom_chg_por;
	logic [1:0] flag_clr;
	logic [1:0] temp_chg;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `PWS_OFS_STATUS) || (a == `PWS_OFS_IRQ_FLAG) ||
			(a == `PWS_OFS_IRQ_MASK) || (a == `PWS_OFS_WD_CTRL) ||
			(a == `PWS_OFS_CONFIG) || (a == `PWS_OFS_IDENT);
	endfunction

	// Period in timebase ticks: 16, 32, 64 or 128 seconds.
	function automatic logic [11:0] period_ticks(input logic [1:0] sel);
		period_ticks = 12'(`PWS_WD_MIN_TICKS) << sel;
	endfunction

	function automatic logic [31:0] read_word(
		input pws_pkg::pws_state_t s,
		input logic [7:0] a
	);
		logic [31:0] w;
		w = 32'h0;
		case (a)
			`PWS_OFS_STATUS: begin
				w[`PWS_ST_TEMP_LOW] = s.temp_stat[0];
				w[`PWS_ST_TEMP_HIGH] = s.temp_stat[1];
				w[`PWS_ST_OVERTEMP_LOCKOUT] = s.overtemp_lockout;
				w[`PWS_ST_WD_EXP] = s.wd_exp;
				w[`PWS_ST_RAIL] = s.rail_reg;
				w[`PWS_ST_INQ_LSB +: 2] = s.sync2.in_qual;
			end
			`PWS_OFS_IRQ_FLAG: w[1:0] = s.flags;
			`PWS_OFS_IRQ_MASK: w[1:0] = s.mask;
			`PWS_OFS_WD_CTRL: begin
				w[`PWS_WD_EN] = s.wd_en;
				w[`PWS_WD_KICK] = 1'b0;
				w[`PWS_WD_PER_LSB +: 2] = s.wd_per;
				w[`PWS_WD_LOCK] = s.lock;
			end
			`PWS_OFS_CONFIG: begin
				w[`PWS_CFG_USB_SUSP] = s.usb_susp;
				w[`PWS_CFG_PULLUP] = s.pullup_sel;
			end
			`PWS_OFS_IDENT: w[3:0] = `PWS_CHIP_ID; // Arbitrary value.
			default: w = 32'h0;
		endcase
		read_word = w;
	endfunction

	always_comb begin
		pins.temp_low = TEMP_ABOVE_80_IN;
		pins.temp_high = TEMP_ABOVE_100_IN;
		pins.temp_over = TEMP_ABOVE_165_IN;
		pins.temp_rel = TEMP_BELOW_150_IN;
		pins.sys_por = SYS_BELOW_POR_IN;
		pins.chg_por = CHG_BELOW_POR_IN;
		pins.chg_uvlo = CHG_UVLO_IN;
		pins.in_qual = INPUT_QUALITY_IN;
		pins.strap_lock = STRAP_LOCK_IN;
		pins.strap_en = STRAP_WD_EN_IN;
	end

	always_comb begin
		nx = st;
		nx.sync1 = pins;
		nx.sync2 = st.sync1;
		if (st.cap_cnt != 2'h3) begin
			nx.cap_cnt = st.cap_cnt + 2'h1;
		end

		// Reset domains, evaluated from synchronised comparator levels and the unsynchronised shutdown input.
		dom_sys_por = st.sync2.sys_por;
		dom_sys = dom_sys_por | SHUTDOWN_TRANS_IN;
		dom_chg_por = st.sync2.chg_por;

		// Free-running timebase; bus traffic never touches it.
		tick = 1'b0;
		if (st.tick_cnt == 25'(TICK_CYCLES - 1)) begin
			nx.tick_cnt = 25'h0;
			tick = 1'b1;
		end else begin
			nx.tick_cnt = st.tick_cnt + 25'h1;
		end

		// Write channel: address and data may come in either order.
		if (AXI_AWVALID_IN && st.awready) begin
			nx.aw_got = 1'b1;
			nx.awaddr = AXI_AWADDR_IN;
		end
		if (AXI_WVALID_IN && st.wready) begin
			nx.w_got = 1'b1;
			nx.wdata = AXI_WDATA_IN;
			nx.wstrb = AXI_WSTRB_IN;
		end
		if (st.bvalid && AXI_BREADY_IN) begin
			nx.bvalid = 1'b0;
		end
		wr_go = st.aw_got && st.w_got && !st.bvalid;
		// Every field lives in byte lane 0, so only that strobe matters.
		wr_lo = wr_go && st.wstrb[0];
		if (wr_go) begin
			nx.aw_got = 1'b0;
			nx.w_got = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = mapped(st.awaddr) ? `PWS_RESP_OKAY :
				`PWS_RESP_SLVERR;
		end
		nx.awready = !nx.aw_got && !nx.bvalid;
		nx.wready = !nx.w_got && !nx.bvalid;

		// Read channel.
		if (st.rvalid && AXI_RREADY_IN) begin
			nx.rvalid = 1'b0;
		end
		if (AXI_ARVALID_IN && st.arready) begin
			nx.rvalid = 1'b1;
			nx.rdata = read_word(st, AXI_ARADDR_IN);
			nx.rresp = mapped(AXI_ARADDR_IN) ? `PWS_RESP_OKAY :
				`PWS_RESP_SLVERR;
		end
		nx.arready = !nx.rvalid;

		// Register writes.
		flag_clr = 2'h0;
		kick = 1'b0;
		if (wr_lo) begin
			case (st.awaddr)
				`PWS_OFS_IRQ_FLAG: flag_clr = st.wdata[1:0];
				`PWS_OFS_IRQ_MASK: nx.mask = st.wdata[1:0];
				`PWS_OFS_WD_CTRL: begin
					kick = st.wdata[`PWS_WD_KICK];
					nx.wd_per = st.wdata[`PWS_WD_PER_LSB +: 2];
					if (!st.lock) begin
						nx.wd_en = st.wdata[`PWS_WD_EN];
					end else if (st.wdata[`PWS_WD_EN]) begin
						nx.wd_en = 1'b1;
					end
				end
				`PWS_OFS_CONFIG: begin
					nx.usb_susp = st.wdata[`PWS_CFG_USB_SUSP];
					nx.pullup_sel = st.wdata[`PWS_CFG_PULLUP];
				end
				default: begin
				end
			endcase
		end

		// Watchdog counter in timebase ticks.
		exp_set = 1'b0;
		if (!st.wd_en) begin
			nx.wd_cnt = 12'h0;
		end else if (kick) begin
			nx.wd_cnt = 12'h0;
		end else if (tick) begin
			if (st.wd_cnt + 12'h1 >= period_ticks(st.wd_per)) begin
				exp_set = 1'b1;
				nx.wd_cnt = 12'h0;
			end else begin
				nx.wd_cnt = st.wd_cnt + 12'h1;
			end
		end
		// A new expiry wins over the controller's clear.
		nx.wd_exp = (st.wd_exp & ~RESET_ACTIONS_IN) | exp_set;

		// Temperature alarms and lockout with hysteresis.
		nx.temp_stat = {st.sync2.temp_high, st.sync2.temp_low};
		temp_chg = nx.temp_stat ^ st.temp_stat;
		if (st.sync2.temp_over) begin
			nx.overtemp_lockout = 1'b1;
		end else if (st.sync2.temp_rel) begin
			nx.overtemp_lockout = 1'b0;
		end
		// Hardware set wins over a same-cycle software clear.
		nx.flags = (st.flags & ~flag_clr) | temp_chg;

		// Domain resets put bits back to their defaults.
		if (dom_sys) begin
			nx.wd_en = st.en_def;
			nx.wd_per = `PWS_PER_RST;
			nx.wd_cnt = 12'h0;
			nx.mask = `PWS_MASK_RST;
			nx.flags = temp_chg;
		end
		if (dom_sys_por) begin
			nx.pullup_sel = 1'b0;
		end
		if (dom_chg_por) begin
			nx.usb_susp = 1'b0;
		end

		// Straps are caught once, after they have passed the synchroniser.
		if (st.cap_cnt == 2'h2) begin
			nx.lock = st.sync2.strap_lock;
			nx.en_def = st.sync2.strap_en;
			nx.wd_en = st.sync2.strap_en;
		end

		nx.sys_por = dom_sys_por;
		nx.sys_rst = dom_sys;
		nx.chg_por_rst = dom_chg_por;
		nx.chg_pg_rst = dom_chg_por | st.usb_susp |
			st.sync2.chg_uvlo;
		nx.rail_reg = (st.sync2.in_qual == `PWS_INQ_VALID) &&
			!nx.usb_susp;
		nx.irq_oe = |(nx.flags & ~nx.mask);
		nx.irq_o = 1'b0;
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			st <= '0;
			st.wd_per <= `PWS_PER_RST;
			st.mask <= `PWS_MASK_RST;
		end else if (CE_IN) begin
			st <= nx;
		end
	end

	assign AXI_AWREADY_OUT = st.awready;
	assign AXI_WREADY_OUT = st.wready;
	assign AXI_BRESP_OUT = st.bresp;
	assign AXI_BVALID_OUT = st.bvalid;
	assign AXI_ARREADY_OUT = st.arready;
	assign AXI_RDATA_OUT = st.rdata;
	assign AXI_RRESP_OUT = st.rresp;
	assign AXI_RVALID_OUT = st.rvalid;
	assign IRQ_N_OUT = st.irq_o;
	assign IRQ_N_OE_OUT = st.irq_oe;
	assign WD_EXPIRED_OUT = st.wd_exp;
	assign OVERTEMP_LOCKOUT_OUT = st.overtemp_lockout;
	assign RAIL_FROM_REG_OUT = st.rail_reg;
	assign WEAK_PULLUP_OUT = st.pullup_sel;
	assign SYS_POR_OUT = st.sys_por;
	assign SYS_RST_OUT = st.sys_rst;
	assign CHG_PG_RST_OUT = st.chg_pg_rst;
	assign CHG_POR_OUT = st.chg_por_rst;

endmodule

`default_nettype wire

// [tb/pws_host.sv]
`default_nettype none

module pws_host (
	input wire logic oe_in, // pull-low enable
	output logic line_out // wire level seen by host
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released pin floats up through the board pullup.
	assign line_out = oe_in ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// [tb/pws_sva.sv]
`default_nettype none

module pws_sva (
	input wire logic CLK_IN, // clk
	input wire logic RST_B_IN, // rst
	input wire logic CE_IN, // run
	input wire logic AXI_AWVALID_IN, // aw
	input wire logic AXI_AWREADY_OUT, // aw
	input wire logic AXI_WVALID_IN, // w
	input wire logic AXI_WREADY_OUT, // w
	input wire logic [1:0] AXI_BRESP_OUT, // b
	input wire logic AXI_BVALID_OUT, // b
	input wire logic AXI_BREADY_IN, // b
	input wire logic AXI_ARVALID_IN, // ar
	input wire logic AXI_ARREADY_OUT, // ar
	input wire logic [31:0] AXI_RDATA_OUT, // r
	input wire logic AXI_RVALID_OUT, // r
	input wire logic AXI_RREADY_IN, // r
	input wire logic TEMP_ABOVE_165_IN, // hot
	input wire logic TEMP_BELOW_150_IN, // cool
	input wire logic CHG_UVLO_IN, // uvlo
	input wire logic SHUTDOWN_TRANS_IN, // off
	input wire logic RESET_ACTIONS_IN, // clr
	input wire logic IRQ_N_OUT, // irq
	input wire logic WD_EXPIRED_OUT, // wd
	input wire logic OVERTEMP_LOCKOUT_OUT, // lock
	input wire logic SYS_POR_OUT, // por
	input wire logic SYS_RST_OUT, // rst
	input wire logic CHG_PG_RST_OUT, // pg
	input wire logic CHG_POR_OUT // cpor
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN || !CE_IN);
	sequence s_wr_taken;
		AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
	endsequence
	sequence s_rd_taken;
		AXI_ARVALID_IN && AXI_ARREADY_OUT;
	endsequence
	a_write_answer: assert property (s_wr_taken |-> ##[1:3] AXI_BVALID_OUT)
		else $error("write response missing");
	a_read_answer: assert property (s_rd_taken |-> ##[1:2] AXI_RVALID_OUT)
		else $error("read response missing");
	a_bresp_holds: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=>
		AXI_BVALID_OUT && $stable(AXI_BRESP_OUT)) else $error("bresp dropped");
	a_rdata_holds: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=>
		AXI_RVALID_OUT && $stable(AXI_RDATA_OUT)) else $error("rdata dropped");
	a_aw_refused: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT)
		else $error("aw ready during response");
	a_irq_drive_low: assert property (IRQ_N_OUT == 1'b0)
		else $error("irq pin drives high");
	a_overtemp_lockout_sets: assert property (TEMP_ABOVE_165_IN [*4] |=> OVERTEMP_LOCKOUT_OUT)
		else $error("lockout not entered");
	a_overtemp_lockout_clears: assert property ((!TEMP_ABOVE_165_IN && TEMP_BELOW_150_IN)
		[*4] |=> !OVERTEMP_LOCKOUT_OUT) else $error("lockout not left");
	a_expiry_sticky: assert property (WD_EXPIRED_OUT && !RESET_ACTIONS_IN |=>
		WD_EXPIRED_OUT) else $error("expiry flag lost");
	a_por_in_rst: assert property (SYS_POR_OUT |-> SYS_RST_OUT)
		else $error("por without system reset");
	a_shutdown_rst: assert property (SHUTDOWN_TRANS_IN |=> SYS_RST_OUT)
		else $error("shutdown without system reset");
	a_cpor_in_pg: assert property (CHG_POR_OUT |-> CHG_PG_RST_OUT)
		else $error("charger por without pg reset");
	a_uvlo_in_pg: assert property (CHG_UVLO_IN [*4] |=> CHG_PG_RST_OUT)
		else $error("uvlo without pg reset");
endmodule

bind pws_supervisor pws_sva pws_sva_inst (.CLK_IN, .RST_B_IN, .CE_IN,
	.AXI_AWVALID_IN, .AXI_AWREADY_OUT, .AXI_WVALID_IN, .AXI_WREADY_OUT,
	.AXI_BRESP_OUT, .AXI_BVALID_OUT, .AXI_BREADY_IN, .AXI_ARVALID_IN,
	.AXI_ARREADY_OUT, .AXI_RDATA_OUT, .AXI_RVALID_OUT, .AXI_RREADY_IN,
	.TEMP_ABOVE_165_IN, .TEMP_BELOW_150_IN, .CHG_UVLO_IN, .SHUTDOWN_TRANS_IN,
	.RESET_ACTIONS_IN, .IRQ_N_OUT, .WD_EXPIRED_OUT, .OVERTEMP_LOCKOUT_OUT, .SYS_POR_OUT,
	.SYS_RST_OUT, .CHG_PG_RST_OUT, .CHG_POR_OUT);

`default_nettype wire

// [tb/tb_pws_supervisor.sv]
`include "pws_consts.svh"
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tb_pws_supervisor;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_IN = 1'b0, RST_B_IN = 1'b0, CE_IN = 1'b1;
	logic [7:0] AXI_AWADDR_IN = 8'h00, AXI_ARADDR_IN = 8'h00;
	logic [31:0] AXI_WDATA_IN = 32'h0;
	logic [3:0] AXI_WSTRB_IN = 4'hf;
	logic AXI_AWVALID_IN = 1'b0, AXI_WVALID_IN = 1'b0, AXI_BREADY_IN = 1'b0;
	logic AXI_ARVALID_IN = 1'b0, AXI_RREADY_IN = 1'b0;
	logic TEMP_ABOVE_80_IN = 1'b0, TEMP_ABOVE_100_IN = 1'b0;
	logic TEMP_ABOVE_165_IN = 1'b0, TEMP_BELOW_150_IN = 1'b1;
	logic SYS_BELOW_POR_IN = 1'b0, CHG_BELOW_POR_IN = 1'b0, CHG_UVLO_IN = 1'b0;
	logic [1:0] INPUT_QUALITY_IN = 2'h0;
	logic STRAP_LOCK_IN = 1'b0, STRAP_WD_EN_IN = 1'b0;
	logic SHUTDOWN_TRANS_IN = 1'b0, RESET_ACTIONS_IN = 1'b0;
	logic AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT, AXI_ARREADY_OUT;
	logic AXI_RVALID_OUT, IRQ_N_OUT, IRQ_N_OE_OUT, WD_EXPIRED_OUT, OVERTEMP_LOCKOUT_OUT;
	logic RAIL_FROM_REG_OUT, WEAK_PULLUP_OUT, SYS_POR_OUT, SYS_RST_OUT;
	logic CHG_PG_RST_OUT, CHG_POR_OUT, irq_line;
	logic [1:0] AXI_BRESP_OUT, AXI_RRESP_OUT, rs;
	logic [31:0] AXI_RDATA_OUT, rv;
	int failures = 0, tests_run = 0, cyc = 0, n;

	// A short tick keeps the 16 s period at 1024 cycles.
	pws_supervisor #(.TICK_CYCLES(4)) pws_supervisor_inst (.CLK_IN, .RST_B_IN,
		.CE_IN, .AXI_AWADDR_IN, .AXI_AWVALID_IN, .AXI_AWREADY_OUT,
		.AXI_WDATA_IN, .AXI_WSTRB_IN, .AXI_WVALID_IN, .AXI_WREADY_OUT,
		.AXI_BRESP_OUT, .AXI_BVALID_OUT, .AXI_BREADY_IN, .AXI_ARADDR_IN,
		.AXI_ARVALID_IN, .AXI_ARREADY_OUT, .AXI_RDATA_OUT, .AXI_RRESP_OUT,
		.AXI_RVALID_OUT, .AXI_RREADY_IN, .TEMP_ABOVE_80_IN, .TEMP_ABOVE_100_IN,
		.TEMP_ABOVE_165_IN, .TEMP_BELOW_150_IN, .SYS_BELOW_POR_IN,
		.CHG_BELOW_POR_IN, .CHG_UVLO_IN, .INPUT_QUALITY_IN, .STRAP_LOCK_IN,
		.STRAP_WD_EN_IN, .SHUTDOWN_TRANS_IN, .RESET_ACTIONS_IN, .IRQ_N_OUT,
		.IRQ_N_OE_OUT, .WD_EXPIRED_OUT, .OVERTEMP_LOCKOUT_OUT, .RAIL_FROM_REG_OUT,
		.WEAK_PULLUP_OUT, .SYS_POR_OUT, .SYS_RST_OUT, .CHG_PG_RST_OUT,
		.CHG_POR_OUT);
	pws_host pws_host_inst (.oe_in(IRQ_N_OE_OUT), .line_out(irq_line));

	always #25 CLK_IN = ~CLK_IN;

	task automatic conclude;
		if (failures == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge CLK_IN) begin
		cyc++;
		if (cyc > 20000) begin
			failures++;
			conclude();
		end
	end

	task automatic step(input int k);
		repeat (k) @(posedge CLK_IN);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge CLK_IN);
		AXI_AWADDR_IN <= a;
		AXI_WDATA_IN <= d;
		AXI_AWVALID_IN <= 1'b1;
		AXI_WVALID_IN <= 1'b1;
		// Response ready stands from the start, so the answer is taken
		// at the very edge at which it is first seen.
		AXI_BREADY_IN <= 1'b1;
		do begin
			@(posedge CLK_IN);
			t++;
			if (AXI_AWREADY_OUT === 1'b1)
				AXI_AWVALID_IN <= 1'b0;
			if (AXI_WREADY_OUT === 1'b1)
				AXI_WVALID_IN <= 1'b0;
		end while (AXI_BVALID_OUT !== 1'b1 && t < 50);
		if (t >= 50)
			failures++;
		rs = AXI_BRESP_OUT;
		AXI_BREADY_IN <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		int t;
		t = 0;
		@(posedge CLK_IN);
		AXI_ARADDR_IN <= a;
		AXI_ARVALID_IN <= 1'b1;
		AXI_RREADY_IN <= 1'b1;
		do begin
			@(posedge CLK_IN);
			t++;
			if (AXI_ARREADY_OUT === 1'b1)
				AXI_ARVALID_IN <= 1'b0;
		end while (AXI_RVALID_OUT !== 1'b1 && t < 50);
		if (t >= 50)
			failures++;
		rv = AXI_RDATA_OUT;
		rs = AXI_RRESP_OUT;
		AXI_RREADY_IN <= 1'b0;
	endtask

	task automatic reboot(input logic lk, input logic en);
		@(posedge CLK_IN);
		STRAP_LOCK_IN <= lk;
		STRAP_WD_EN_IN <= en;
		RST_B_IN <= 1'b0;
		step(10);
		RST_B_IN <= 1'b1;
		step(6);
	endtask

	initial begin
		reboot(1'b0, 1'b0);
		`CHK(irq_line, 1'b1)
		rd(`PWS_OFS_IRQ_MASK);
		`CHK(rv, 32'h3)
		rd(`PWS_OFS_WD_CTRL);
		`CHK(rv, 32'hc)
		rd(8'h40);
		`CHK(rs, `PWS_RESP_SLVERR)
		`CHK(rv, 32'h0)
		for (int p = 0; p < 4; p++) begin
			wr(`PWS_OFS_WD_CTRL, 32'(p << 2));
			rd(`PWS_OFS_WD_CTRL);
			`CHK(rv[3:2], 2'(p))
		end
		TEMP_ABOVE_80_IN <= 1'b1;
		step(6);
		rd(`PWS_OFS_STATUS);
		`CHK(rv[1:0], 2'h1)
		rd(`PWS_OFS_IRQ_FLAG);
		`CHK(rv[1:0], 2'h1)
		`CHK(IRQ_N_OE_OUT, 1'b0)
		wr(`PWS_OFS_IRQ_MASK, 32'h2);
		step(2);
		`CHK(irq_line, 1'b0)
		wr(`PWS_OFS_IRQ_FLAG, 32'h1);
		step(2);
		`CHK(irq_line, 1'b1)
		TEMP_ABOVE_100_IN <= 1'b1;
		step(6);
		rd(`PWS_OFS_IRQ_FLAG);
		`CHK(rv[1:0], 2'h2)
		`CHK(IRQ_N_OE_OUT, 1'b0)
		wr(`PWS_OFS_IRQ_MASK, 32'h0);
		step(2);
		`CHK(IRQ_N_OE_OUT, 1'b1)
		// Without the kick the 1600 cycles below would pass the period.
		wr(`PWS_OFS_WD_CTRL, 32'h1);
		step(800);
		wr(`PWS_OFS_WD_CTRL, 32'h3);
		step(800);
		`CHK(WD_EXPIRED_OUT, 1'b0)
		wr(`PWS_OFS_WD_CTRL, 32'h3);
		n = 0;
		while (WD_EXPIRED_OUT !== 1'b1 && n < 1200) begin
			step(1);
			n++;
		end
		`CHK(n >= 1000 && n <= 1030, 1'b1)
		rd(`PWS_OFS_WD_CTRL);
		`CHK(rv[1:0], 2'h1)
		RESET_ACTIONS_IN <= 1'b1;
		step(1);
		RESET_ACTIONS_IN <= 1'b0;
		wr(`PWS_OFS_WD_CTRL, 32'h0);
		`CHK(WD_EXPIRED_OUT, 1'b0)
		rd(`PWS_OFS_WD_CTRL);
		`CHK(rv[0], 1'b0)
		step(1100);
		`CHK(WD_EXPIRED_OUT, 1'b0)
		INPUT_QUALITY_IN <= 2'h3;
		wr(`PWS_OFS_CONFIG, 32'h2);
		step(5);
		`CHK(RAIL_FROM_REG_OUT, 1'b1)
		`CHK(WEAK_PULLUP_OUT, 1'b1)
		wr(`PWS_OFS_CONFIG, 32'h3);
		step(3);
		`CHK(RAIL_FROM_REG_OUT, 1'b0)
		`CHK(CHG_PG_RST_OUT, 1'b1)
		INPUT_QUALITY_IN <= 2'h1;
		wr(`PWS_OFS_CONFIG, 32'h2);
		step(5);
		`CHK(RAIL_FROM_REG_OUT, 1'b0)
		`CHK(CHG_PG_RST_OUT, 1'b0)
		SYS_BELOW_POR_IN <= 1'b1;
		CHG_BELOW_POR_IN <= 1'b1;
		CHG_UVLO_IN <= 1'b1;
		step(5);
		`CHK(SYS_POR_OUT, 1'b1)
		`CHK(SYS_RST_OUT, 1'b1)
		`CHK(CHG_POR_OUT, 1'b1)
		SYS_BELOW_POR_IN <= 1'b0;
		CHG_BELOW_POR_IN <= 1'b0;
		CHG_UVLO_IN <= 1'b0;
		step(5);
		`CHK(WEAK_PULLUP_OUT, 1'b0)
		rd(`PWS_OFS_IRQ_MASK);
		`CHK(rv, 32'h3)
		TEMP_ABOVE_165_IN <= 1'b1;
		TEMP_BELOW_150_IN <= 1'b0;
		step(5);
		`CHK(OVERTEMP_LOCKOUT_OUT, 1'b1)
		TEMP_ABOVE_165_IN <= 1'b0;
		step(5);
		`CHK(OVERTEMP_LOCKOUT_OUT, 1'b1)
		TEMP_BELOW_150_IN <= 1'b1;
		step(5);
		`CHK(OVERTEMP_LOCKOUT_OUT, 1'b0)
		// With the clock enable low, a hot pin must not reach the lockout.
		CE_IN <= 1'b0;
		TEMP_ABOVE_165_IN <= 1'b1;
		step(6);
		`CHK(OVERTEMP_LOCKOUT_OUT, 1'b0)
		TEMP_ABOVE_165_IN <= 1'b0;
		CE_IN <= 1'b1;
		step(5);
		`CHK(OVERTEMP_LOCKOUT_OUT, 1'b0)
		reboot(1'b1, 1'b0);
		wr(`PWS_OFS_WD_CTRL, 32'h1);
		wr(`PWS_OFS_WD_CTRL, 32'h0);
		rd(`PWS_OFS_WD_CTRL);
		`CHK(rv[4], 1'b1)
		`CHK(rv[0], 1'b1)
		SHUTDOWN_TRANS_IN <= 1'b1;
		step(1);
		SHUTDOWN_TRANS_IN <= 1'b0;
		rd(`PWS_OFS_WD_CTRL);
		`CHK(rv[0], 1'b0)
		reboot(1'b1, 1'b1);
		wr(`PWS_OFS_WD_CTRL, 32'h0);
		rd(`PWS_OFS_WD_CTRL);
		`CHK(rv[0], 1'b1)
		reboot(1'b0, 1'b1);
		rd(`PWS_OFS_WD_CTRL);
		`CHK(rv[0], 1'b1)
		conclude();
	end
endmodule

`default_nettype wire
